//--- rtl/sml_pkg.sv
/*
 * Shared constants, types and register map of the strap and status block.
 * Assumes a single 250 MHz clock and straps that are synchronous to it.
 */
`default_nettype none
package sml_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam int BLINK_PERIOD_NS = 1_000_000_000;
   localparam int BLINK_HALF_CYCLES = BLINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int SETTLE_NS = 64;
   localparam int SETTLE_CYCLES =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W = 5;
   localparam logic [SETTLE_W-1:0] SETTLE_LAST =
      SETTLE_W'(SETTLE_CYCLES - 1);
   localparam int NUM_ERR_FLAGS = 8;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_INT_STAT = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 4'hc;
   localparam int CTRL_W = 2;
   localparam int CTRL_LOAD_BIT = 0;
   localparam int CTRL_PWM_BIT = 1;
   localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
   localparam int NUM_EV = 4;
   localparam int EV_ERR = 0;
   localparam int EV_BUSOFF = 1;
   localparam int EV_RESTART = 2;
   localparam int EV_CAPTURE = 3;
   localparam logic [NUM_EV-1:0] INT_MASK_RST = 4'h0;
   localparam int ST_MASTER = 0;
   localparam int ST_RATE_LSB = 1;
   localparam int ST_BOOT_LSB = 3;
   localparam int ST_FLASH = 5;
   localparam int ST_RUN = 6;
   localparam int ST_ERR = 7;
   localparam int ST_BUSOFF = 8;

   typedef enum logic [1:0] {
      RATE_125K, RATE_250K, RATE_500K, RATE_1000K
   } sml_rate_t;
   typedef enum logic [1:0] {
      BOOT_PARALLEL, BOOT_SERIAL, BOOT_WAIT, BOOT_QUERY
   } sml_boot_t;
   typedef struct packed {
      logic master;
      sml_rate_t rate;
      sml_boot_t boot;
      logic flash_boot;
   } sml_cfg_t;
   typedef struct packed {
      logic role;
      logic rate_hi;
      logic rate_lo;
      logic boot_a;
      logic boot_b;
   } sml_straps_t;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } sml_bus_req_t;
   typedef struct packed {
      logic blue;
      logic green;
      logic red;
      logic yellow;
   } sml_leds_t;
endpackage : sml_pkg
`default_nettype wire

//--- rtl/sml_blink.sv
/*
 * Free-running square wave used as the common 1 Hz blink phase.
 * Assumes the half period in clock cycles is at least one.
 */
`timescale 1ns/100ps
`default_nettype none
module sml_blink import sml_pkg::*; #(
   parameter int HALF = BLINK_HALF_CYCLES
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Blink phase.
   output logic phase
);
   localparam int CW = $clog2(HALF + 1);
   localparam logic [CW-1:0] LAST = CW'(HALF - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic phase;
   } sml_blink_st_t;

   sml_blink_st_t s, n;

   always_comb begin
      n = s;
      if (s.cnt == LAST) begin
         n.cnt = '0;
         n.phase = ~s.phase;
      end else begin
         n.cnt = s.cnt + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign phase = s.phase;

   property p_half_period;
      @(posedge sys_clk) disable iff (!rstn)
      (s.cnt == LAST) |=> (s.phase != $past(s.phase));
   endproperty
   a_half_period: assert property (p_half_period)
      else $error("blink phase missed its toggle");
endmodule : sml_blink
`default_nettype wire

//--- rtl/sml_rst_seq.sv
/*
 * Holds the processor in reset while the wired reset line is low, then
 * samples the straps once and releases it.
 * Assumes the line level is already synchronous to sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module sml_rst_seq import sml_pkg::*; (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Board side.
   input wire logic rst_line,
   input wire sml_straps_t straps,
   // Processor side.
   output logic proc_rst_n,
   output sml_cfg_t cfg,
   output logic restart,
   output logic captured
);
   typedef enum logic [1:0] {
      ST_HOLD, ST_SETTLE, ST_CAPTURE, ST_RUN
   } sml_seq_t;
   typedef struct packed {
      sml_seq_t st;
      logic [SETTLE_W-1:0] cnt;
      sml_cfg_t cfg;
      logic proc_rst_n;
      logic restart;
      logic captured;
   } sml_seq_st_t;

   sml_seq_st_t s, n;

   function automatic sml_cfg_t decode(input sml_straps_t p);
      sml_cfg_t c;
      c.master = p.role;
      unique case ({p.rate_hi, p.rate_lo})
         2'h0: c.rate = RATE_125K;
         2'h1: c.rate = RATE_250K;
         2'h2: c.rate = RATE_500K;
         2'h3: c.rate = RATE_1000K;
      endcase
      unique case ({p.boot_a, p.boot_b})
         2'h0: c.boot = BOOT_PARALLEL;
         2'h1: c.boot = BOOT_SERIAL;
         2'h2: c.boot = BOOT_WAIT;
         2'h3: c.boot = BOOT_QUERY;
      endcase
      c.flash_boot = (c.boot == BOOT_QUERY);
      return c;
   endfunction : decode

   always_comb begin
      n = s;
      n.restart = 1'b0;
      n.captured = 1'b0;
      unique case (s.st)
         ST_HOLD: begin
            n.proc_rst_n = 1'b0;
            if (rst_line) begin
               n.st = ST_SETTLE;
               n.cnt = '0;
            end
         end
         ST_SETTLE: begin
            if (!rst_line) begin
               n.st = ST_HOLD;
            end else if (s.cnt == SETTLE_LAST) begin
               n.st = ST_CAPTURE;
            end else begin
               n.cnt = s.cnt + 1'b1;
            end
         end
         ST_CAPTURE: begin
            if (!rst_line) begin
               n.st = ST_HOLD;
            end else begin
               n.cfg = decode(straps);
               n.captured = 1'b1;
               n.proc_rst_n = 1'b1;
               n.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!rst_line) begin
               n.st = ST_HOLD;
               n.proc_rst_n = 1'b0;
               n.restart = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign proc_rst_n = s.proc_rst_n;
   assign cfg = s.cfg;
   assign restart = s.restart;
   assign captured = s.captured;

   property p_line_holds;
      @(posedge sys_clk) disable iff (!rstn)
      !rst_line |=> !proc_rst_n && (s.st == ST_HOLD);
   endproperty
   a_line_holds: assert property (p_line_holds)
      else $error("processor left reset while line low");

   property p_restart;
      @(posedge sys_clk) disable iff (!rstn)
      (s.st == ST_RUN) && !rst_line |=> restart && !proc_rst_n;
   endproperty
   a_restart: assert property (p_restart)
      else $error("line low did not restart processor");

   property p_cfg_held;
      @(posedge sys_clk) disable iff (!rstn)
      proc_rst_n && $past(proc_rst_n) |-> $stable(cfg);
   endproperty
   a_cfg_held: assert property (p_cfg_held)
      else $error("strap capture changed while running");

   property p_role;
      @(posedge sys_clk) disable iff (!rstn)
      (s.st == ST_CAPTURE) && rst_line
         |=> captured && (cfg.master == $past(straps.role));
   endproperty
   a_role: assert property (p_role)
      else $error("role not taken from strap");

   property p_rate;
      @(posedge sys_clk) disable iff (!rstn)
      (s.st == ST_CAPTURE) && rst_line |=>
         ((cfg.rate == RATE_1000K) ==
          ($past(straps.rate_hi) && $past(straps.rate_lo))) &&
         ((cfg.rate == RATE_125K) ==
          (!$past(straps.rate_hi) && !$past(straps.rate_lo)));
   endproperty
   a_rate: assert property (p_rate)
      else $error("bit rate decode wrong");

   property p_boot;
      @(posedge sys_clk) disable iff (!rstn)
      (s.st == ST_CAPTURE) && rst_line |=>
         ((cfg.boot == BOOT_QUERY) ==
          ($past(straps.boot_a) && $past(straps.boot_b)));
   endproperty
   a_boot: assert property (p_boot)
      else $error("boot mode decode wrong");

   property p_flash;
      @(posedge sys_clk) disable iff (!rstn)
      proc_rst_n && (cfg.boot == BOOT_QUERY) |-> cfg.flash_boot;
   endproperty
   a_flash: assert property (p_flash)
      else $error("mode-query boot not from flash");

   c_master: cover property (@(posedge sys_clk) disable iff (!rstn)
      captured && cfg.master);
   c_restart: cover property (@(posedge sys_clk) disable iff (!rstn)
      restart);
endmodule : sml_rst_seq
`default_nettype wire

//--- rtl/sml_top.sv
/*
 * Board control block: reset hold and strap capture, status indicators,
 * dummy load and regulator mode, with a small register port and interrupt.
 * Assumes all inputs are synchronous to sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module sml_top import sml_pkg::*; #(
   parameter int BLINK_HALF = BLINK_HALF_CYCLES,
   parameter int NUM_ERR = NUM_ERR_FLAGS
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Register port.
   input wire sml_bus_req_t bus_req,
   output logic [DATA_W-1:0] rd_data,
   output logic irq,
   // Straps and wired reset line.
   input wire sml_straps_t straps,
   input wire logic rst_line,
   // CAN controller status.
   input wire logic [NUM_ERR-1:0] can_err_flags,
   input wire logic can_bus_off,
   input wire logic core_alive,
   // Processor side.
   output logic processor_reset_n,
   output sml_cfg_t node_cfg,
   output logic can_initiate,
   // Board outputs.
   output sml_leds_t leds,
   output logic dummy_load_enable,
   output logic reg_mode_pwm
);
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [NUM_EV-1:0] int_stat;
      logic [NUM_EV-1:0] int_mask;
      logic [DATA_W-1:0] rd_data;
      logic irq;
      sml_leds_t leds;
      logic can_initiate;
      logic err_seen;
      logic busoff_seen;
   } sml_top_st_t;

   sml_top_st_t s, n;
   logic phase;
   logic restart;
   logic captured;
   logic err_any;
   logic run;
   logic [NUM_EV-1:0] ev;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] rd_mux;

   // Reset hold and strap capture.
   sml_rst_seq u_seq (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .rst_line(rst_line),
      .straps(straps),
      .proc_rst_n(processor_reset_n),
      .cfg(node_cfg),
      .restart(restart),
      .captured(captured)
   );

   // Common blink phase for all indicators.
   sml_blink #(
      .HALF(BLINK_HALF)
   ) u_blink (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .phase(phase)
   );

   assign err_any = |can_err_flags;
   assign run = processor_reset_n;

   // Events that raise sticky status bits.
   always_comb begin
      ev = '0;
      ev[EV_ERR] = err_any & ~s.err_seen;
      ev[EV_BUSOFF] = can_bus_off & ~s.busoff_seen;
      ev[EV_RESTART] = restart;
      ev[EV_CAPTURE] = captured;
   end

   // Live state as seen by software.
   always_comb begin
      status_word = '0;
      status_word[ST_MASTER] = node_cfg.master;
      status_word[ST_RATE_LSB +: 2] = node_cfg.rate;
      status_word[ST_BOOT_LSB +: 2] = node_cfg.boot;
      status_word[ST_FLASH] = node_cfg.flash_boot;
      status_word[ST_RUN] = run;
      status_word[ST_ERR] = err_any;
      status_word[ST_BUSOFF] = can_bus_off;
   end

   // Read data select; unmapped addresses read as zero.
   always_comb begin
      rd_mux = '0;
      unique case (bus_req.addr)
         OFS_CTRL: rd_mux[CTRL_W-1:0] = s.ctrl;
         OFS_STATUS: rd_mux = status_word;
         OFS_INT_STAT: rd_mux[NUM_EV-1:0] = s.int_stat;
         OFS_INT_MASK: rd_mux[NUM_EV-1:0] = s.int_mask;
         default: rd_mux = '0;
      endcase
   end

   always_comb begin
      n = s;
      n.err_seen = err_any;
      n.busoff_seen = can_bus_off;
      n.rd_data = '0;
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            OFS_CTRL: n.ctrl = bus_req.wdata[CTRL_W-1:0];
            OFS_INT_STAT:
               n.int_stat = s.int_stat & ~bus_req.wdata[NUM_EV-1:0];
            OFS_INT_MASK: n.int_mask = bus_req.wdata[NUM_EV-1:0];
            default: n.ctrl = s.ctrl;
         endcase
      end
      // A new event wins over a clear in the same cycle.
      n.int_stat = n.int_stat | ev;
      if (bus_req.rd) begin
         n.rd_data = rd_mux;
      end
      n.irq = |(n.int_stat & n.int_mask);
      n.leds.blue = phase & err_any;
      n.leds.green = phase & can_bus_off;
      n.leds.red = phase & run & core_alive;
      n.leds.yellow = phase & run & node_cfg.master;
      n.can_initiate = run & node_cfg.master;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.ctrl <= CTRL_RST;
         s.int_mask <= INT_MASK_RST;
      end else begin
         s <= n;
      end
   end

   assign rd_data = s.rd_data;
   assign irq = s.irq;
   assign leds = s.leds;
   assign can_initiate = s.can_initiate;
   assign dummy_load_enable = s.ctrl[CTRL_LOAD_BIT];
   assign reg_mode_pwm = s.ctrl[CTRL_PWM_BIT];

   property p_blue_on;
      @(posedge sys_clk) disable iff (!rstn)
      err_any && phase |=> leds.blue;
   endproperty
   a_blue_on: assert property (p_blue_on)
      else $error("blue off during error");

   property p_blue_off;
      @(posedge sys_clk) disable iff (!rstn)
      !err_any |=> !leds.blue;
   endproperty
   a_blue_off: assert property (p_blue_off)
      else $error("blue lit without error");

   property p_green;
      @(posedge sys_clk) disable iff (!rstn)
      (can_bus_off && phase |=> leds.green) and
      (!can_bus_off |=> !leds.green);
   endproperty
   a_green: assert property (p_green)
      else $error("green does not follow bus-off");

   property p_red;
      @(posedge sys_clk) disable iff (!rstn)
      leds.red |-> $past(run) && $past(core_alive) && $past(phase);
   endproperty
   a_red: assert property (p_red)
      else $error("heartbeat lit while not running");

   property p_master;
      @(posedge sys_clk) disable iff (!rstn)
      (leds.yellow || can_initiate) |->
         $past(node_cfg.master) && $past(run);
   endproperty
   a_master: assert property (p_master)
      else $error("master indication without master role");

   property p_load;
      @(posedge sys_clk) disable iff (!rstn)
      bus_req.wr && (bus_req.addr == OFS_CTRL) |=>
         dummy_load_enable == $past(bus_req.wdata[CTRL_LOAD_BIT]);
   endproperty
   a_load: assert property (p_load)
      else $error("dummy load did not follow write");

   property p_pwm;
      @(posedge sys_clk) disable iff (!rstn)
      bus_req.wr && (bus_req.addr == OFS_CTRL) |=>
         reg_mode_pwm == $past(bus_req.wdata[CTRL_PWM_BIT]);
   endproperty
   a_pwm: assert property (p_pwm)
      else $error("regulator mode did not follow write");

   property p_set_wins;
      @(posedge sys_clk) disable iff (!rstn)
      ev[EV_ERR] |=> s.int_stat[EV_ERR];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("error event lost");

   property p_rd_zero;
      @(posedge sys_clk) disable iff (!rstn)
      !bus_req.rd |=> (rd_data == '0);
   endproperty
   a_rd_zero: assert property (p_rd_zero)
      else $error("read data outside its cycle");

   c_green: cover property (@(posedge sys_clk) disable iff (!rstn)
      leds.green);
   c_irq: cover property (@(posedge sys_clk) disable iff (!rstn)
      $rose(irq));
   c_yellow: cover property (@(posedge sys_clk) disable iff (!rstn)
      leds.yellow);
endmodule : sml_top
`default_nettype wire

//--- verification/sml_board_model.sv
/*
 * Board model: regulator reset output, push button and strap switches.
 * Assumes the bench drives the button and strap settings on sys_clk edges.
 */
`timescale 1ns/100ps
`default_nettype none
module sml_board_model import sml_pkg::*; #(
   parameter int RAIL_CYC = 10
) (
   // Clock and power-on.
   input wire logic sys_clk,
   input wire logic rstn,
   // Bench controls.
   input wire logic button,
   input wire sml_straps_t strap_set,
   // Board lines.
   output logic rst_line,
   output sml_straps_t straps
);
   int rail_cnt;
   logic rail_good;

   // The regulator holds its output low until the rail has settled.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rail_cnt <= 0;
      end else if (rail_cnt < RAIL_CYC) begin
         rail_cnt <= rail_cnt + 1;
      end
   end
   assign rail_good = (rail_cnt >= RAIL_CYC);
   // Pulled-up wired line; either source pulls it low.
   assign rst_line = rail_good & ~button;
   assign straps = strap_set;
endmodule : sml_board_model
`default_nettype wire

//--- verification/sml_top_tb.sv
/*
 * Self-checking bench for the board control block.
 * Assumes the board model supplies the reset line and the straps.
 */
`timescale 1ns/100ps
`default_nettype none
module sml_top_tb import sml_pkg::*; ;
   localparam int HALF = 4;
   localparam int LIMIT = 3000;
   logic sys_clk, rstn, button, irq, processor_reset_n, can_initiate;
   logic dummy_load_enable, reg_mode_pwm, rst_line, can_bus_off, core_alive;
   logic [7:0] can_err_flags;
   logic [DATA_W-1:0] rd_data;
   sml_bus_req_t bus_req;
   sml_straps_t straps, strap_set, s;
   sml_cfg_t node_cfg, exp_cfg;
   sml_leds_t leds;
   int error_cnt, cmp_count, n;
   int cyc = 0;

   sml_top #(.BLINK_HALF(HALF), .NUM_ERR(8)) i_dut (
      .sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req),
      .rd_data(rd_data), .irq(irq), .straps(straps), .rst_line(rst_line),
      .can_err_flags(can_err_flags), .can_bus_off(can_bus_off),
      .core_alive(core_alive), .processor_reset_n(processor_reset_n),
      .node_cfg(node_cfg), .can_initiate(can_initiate), .leds(leds),
      .dummy_load_enable(dummy_load_enable), .reg_mode_pwm(reg_mode_pwm)
   );

   sml_board_model i_board (
      .sys_clk(sys_clk), .rstn(rstn), .button(button),
      .strap_set(strap_set), .rst_line(rst_line), .straps(straps)
   );

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1;
      chk(rd_data, e);
   endtask : rd_chk

   task automatic led_cnt(input int eb, input int eg, input int er,
                          input int ey);
      logic [31:0] c [4];
      c = '{32'h0, 32'h0, 32'h0, 32'h0};
      repeat (4 * HALF) begin
         @(posedge sys_clk);
         #1;
         c[0] += 32'(leds.blue);
         c[1] += 32'(leds.green);
         c[2] += 32'(leds.red);
         c[3] += 32'(leds.yellow);
      end
      chk(c[0], eb);
      chk(c[1], eg);
      chk(c[2], er);
      chk(c[3], ey);
   endtask : led_cnt

   task automatic boot(input sml_straps_t st);
      @(posedge sys_clk);
      button <= 1'b1;
      strap_set <= st;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(processor_reset_n, 1'b0);
      @(posedge sys_clk);
      button <= 1'b0;
      n = 0;
      while (processor_reset_n !== 1'b1 && n < 40) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk(n, 18);
   endtask : boot

   initial begin
      rstn = 1'b0;
      button = 1'b0;
      bus_req = '0;
      strap_set = '0;
      can_err_flags = '0;
      can_bus_off = 1'b0;
      core_alive = 1'b1;
      error_cnt = 0;
      cmp_count = 0;
      repeat (8) @(posedge sys_clk);
      #1;
      chk(processor_reset_n, 1'b0);
      chk(leds, 4'h0);
      @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      chk(processor_reset_n, 1'b0);
      n = 0;
      while (processor_reset_n !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk(processor_reset_n, 1'b1);
      rd_chk(OFS_CTRL, 32'h0);
      rd_chk(OFS_INT_MASK, 32'h0);
      for (int i = 0; i < 4; i++) begin
         s = '{role: i[0], rate_hi: i[1], rate_lo: i[0], boot_a: i[1],
               boot_b: i[0]};
         boot(s);
         exp_cfg = '{master: i[0], rate: sml_rate_t'(i[1:0]),
                     boot: sml_boot_t'(i[1:0]), flash_boot: (i == 3)};
         chk(node_cfg, exp_cfg);
         @(posedge sys_clk);
         #1;
         chk(can_initiate, i[0]);
         rd_chk(OFS_STATUS, {23'h0, 3'h1, exp_cfg.flash_boot, exp_cfg.boot,
                             exp_cfg.rate, exp_cfg.master});
      end
      @(posedge sys_clk);
      strap_set <= '0;
      repeat (30) @(posedge sys_clk);
      #1;
      chk(node_cfg, exp_cfg);
      rd_chk(OFS_INT_STAT, 32'hc);
      chk(irq, 1'b0);
      wr(OFS_INT_STAT, 32'hf);
      wr(OFS_INT_MASK, 32'h1);
      @(posedge sys_clk);
      can_err_flags <= 8'h80;
      can_bus_off <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(irq, 1'b1);
      rd_chk(OFS_STATUS, 32'h1ff);
      rd_chk(OFS_INT_STAT, 32'h3);
      wr(OFS_INT_STAT, 32'h1);
      rd_chk(OFS_INT_STAT, 32'h2);
      chk(irq, 1'b0);
      led_cnt(2 * HALF, 2 * HALF, 2 * HALF, 2 * HALF);
      @(posedge sys_clk);
      can_err_flags <= 8'h00;
      can_bus_off <= 1'b0;
      core_alive <= 1'b0;
      repeat (3) @(posedge sys_clk);
      led_cnt(0, 0, 0, 2 * HALF);
      @(posedge sys_clk);
      can_err_flags <= 8'h01;
      bus_req <= '{addr: OFS_INT_STAT, wdata: 32'h1, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
      rd_chk(OFS_INT_STAT, 32'h3);
      chk(irq, 1'b1);
      wr(OFS_CTRL, 32'h3);
      #1;
      chk(dummy_load_enable, 1'b1);
      chk(reg_mode_pwm, 1'b1);
      wr(OFS_CTRL, 32'h2);
      #1;
      chk(dummy_load_enable, 1'b0);
      chk(reg_mode_pwm, 1'b1);
      wr(4'h2, 32'hffffffff);
      rd_chk(4'h2, 32'h0);
      rd_chk(OFS_CTRL, 32'h2);
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(processor_reset_n, 1'b0);
      chk(reg_mode_pwm, 1'b0);
      @(posedge sys_clk);
      rstn <= 1'b1;
      n = 0;
      while (processor_reset_n !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk(n, 28);
      chk(node_cfg, 32'h0);
      rd_chk(OFS_CTRL, 32'h0);
      summarize();
   end
endmodule : sml_top_tb
`default_nettype wire
